//--- logic/capture_pkg.sv
// Constants and carrier types for the input capture unit
//
// How it works
// - A qualifying event on the selected pin or internal trigger snapshots the capture timer.
// - The capture timer is a dedicated synchronous up counter, 16 or 32 bits wide.
// - A capture pushes the snapshot into a FIFO that software drains later, unless the FIFO is full and not popped.
// - The running count is readable through a readback that lags the live counter.
// - The mode comes from the 4-bit field at bits 3:0 together with the wide select at bit 5.
// - Mode 0000 captures on every edge of the input.
// - Mode 0001 captures on every rising edge.
// - Mode 0010 captures on every falling edge.
// - Mode 0011 captures on every rising and every falling edge.
// - Mode 0100 captures on every fourth rising edge.
// - Mode 0101 captures on every sixteenth rising edge.
// - Wide select 1 stores 32-bit values, 0 stores 16-bit values.
package capture_pkg;
  localparam int MODE_POS = 0;
  localparam int CAPSEL_POS = 4;
  localparam int WIDE_POS = 5;
  localparam logic [3:0] MODE_EDGE = 4'h0;
  localparam logic [3:0] MODE_RISE = 4'h1;
  localparam logic [3:0] MODE_FALL = 4'h2;
  localparam logic [3:0] MODE_BOTH = 4'h3;
  localparam logic [3:0] MODE_RISE4 = 4'h4;
  localparam logic [3:0] MODE_RISE16 = 4'h5;
  localparam logic [3:0] PRESC_LAST4 = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hF;
  localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
  localparam int READBACK_STAGES = 2;

  typedef struct packed {
    logic wide_timer_select;
    logic capture_select;
    logic [3:0] capture_mode_field;
  } capture_control_one_t;

  typedef struct packed {
    logic valid;
    logic [31:0] count;
  } capture_word_t;
endpackage

//--- logic/input_capture_unit.sv
// Input capture unit: edge qualifier, dedicated timer and capture FIFO
`timescale 1ns/1ps
module input_capture_unit #(
  parameter int DEPTH = 4,
  parameter int PTR_W = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input capture_pkg::capture_control_one_t capture_control_one,
  input wire logic trigger_select,
  // Event sources
  input wire logic capture_pin,
  input wire logic internal_trigger,
  // FIFO read side
  input wire logic fifo_pop,
  output logic fifo_valid,
  output logic [31:0] fifo_data,
  output logic fifo_overflow,
  // Timer readback
  output logic [31:0] capture_timer_readback
);
  import capture_pkg::*;

  initial begin
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin
      $error("DEPTH must be a power of two equal to 2**PTR_W");
    end
  end

  // Pin synchroniser; the first stage feeds only the second
  logic pin_s1, pin_s2, src_prev;
  logic src;
  logic [3:0] mode_prev;
  logic [3:0] presc, next_presc;
  logic [31:0] timer, next_timer;
  logic [31:0] rb [READBACK_STAGES];
  logic [31:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr, next_rd;
  logic [PTR_W:0] cnt, next_cnt;
  logic overflow, next_overflow;
  logic rise, fall, capture, push, pop, enabled, mode_change;
  logic [31:0] snap;

  assign src = trigger_select ? internal_trigger : pin_s2;
  assign enabled = capture_control_one.capture_select;
  assign mode_change = capture_control_one.capture_mode_field != mode_prev;
  assign rise = src & ~src_prev;
  assign fall = ~src & src_prev;

  always_comb begin
    capture = 1'b0;
    next_presc = presc;
    case (capture_control_one.capture_mode_field)
      MODE_EDGE: capture = rise | fall;
      MODE_RISE: capture = rise;
      MODE_FALL: capture = fall;
      MODE_BOTH: capture = rise | fall;
      MODE_RISE4: begin
        if (rise) begin
          capture = presc == PRESC_LAST4;
          next_presc = capture ? 4'h0 : presc + 4'h1;
        end
      end
      MODE_RISE16: begin
        if (rise) begin
          capture = presc == PRESC_LAST16;
          next_presc = presc + 4'h1;
        end
      end
      default: capture = 1'b0;
    endcase
    if (!enabled || mode_change) begin
      capture = 1'b0;
      next_presc = 4'h0;
    end
  end

  // Dedicated up counter; narrow mode wraps at 16 bits
  always_comb begin
    next_timer = timer + 32'h1;
    if (!capture_control_one.wide_timer_select) begin
      next_timer = {16'h0, next_timer[15:0]};
    end
    if (!enabled) begin
      next_timer = TIMER_RESET;
    end
  end

  assign snap = capture_control_one.wide_timer_select ? timer : {16'h0, timer[15:0]};

  // A full FIFO drops the new capture and flags overflow; a pop frees room the same cycle
  always_comb begin
    pop = fifo_pop && cnt != '0;
    push = capture && (cnt != (PTR_W+1)'(DEPTH) || pop);
    next_wr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_cnt = cnt + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    next_overflow = overflow | (capture & ~push);
    if (!enabled) begin
      next_overflow = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      src_prev <= 1'b0;
      mode_prev <= MODE_EDGE;
      presc <= 4'h0;
      timer <= TIMER_RESET;
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
      overflow <= 1'b0;
      for (int i = 0; i < READBACK_STAGES; i++) begin
        rb[i] <= TIMER_RESET;
      end
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= TIMER_RESET;
      end
    end else begin
      pin_s1 <= capture_pin;
      pin_s2 <= pin_s1;
      src_prev <= src;
      mode_prev <= capture_control_one.capture_mode_field;
      presc <= next_presc;
      timer <= next_timer;
      wr_ptr <= next_wr;
      rd_ptr <= next_rd;
      cnt <= next_cnt;
      overflow <= next_overflow;
      rb[0] <= timer;
      for (int i = 1; i < READBACK_STAGES; i++) begin
        rb[i] <= rb[i-1];
      end
      if (push) begin
        mem[wr_ptr] <= snap;
      end
    end
  end

  assign fifo_valid = cnt != '0;
  assign fifo_data = mem[rd_ptr];
  assign fifo_overflow = overflow;
  assign capture_timer_readback = rb[READBACK_STAGES-1];

  // Checks
  property p_push_on_capture;
    @(posedge mclk) disable iff (!nrst)
      capture && cnt != (PTR_W+1)'(DEPTH) |=> cnt != '0;
  endproperty
  a_push_on_capture: assert property (p_push_on_capture) else $error("capture not stored");
  // A dropped capture must leave a sticky mark, or software loses an edge silently
  property p_overflow_set;
    @(posedge mclk) disable iff (!nrst)
      capture && cnt == (PTR_W+1)'(DEPTH) && !fifo_pop |=> fifo_overflow;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("drop not flagged");
  property p_timer_idle;
    @(posedge mclk) disable iff (!nrst) !enabled |=> timer == TIMER_RESET;
  endproperty
  a_timer_idle: assert property (p_timer_idle) else $error("timer ran while deselected");
  property p_rise_only;
    @(posedge mclk) disable iff (!nrst)
      capture_control_one.capture_mode_field == MODE_RISE && capture |-> rise;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rise mode took non-rising edge");
  property p_fall_only;
    @(posedge mclk) disable iff (!nrst)
      capture_control_one.capture_mode_field == MODE_FALL && capture |-> fall;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("fall mode took non-falling edge");
  property p_both;
    @(posedge mclk) disable iff (!nrst)
      enabled && !mode_change && capture_control_one.capture_mode_field == MODE_BOTH
      && (rise || fall) |-> capture;
  endproperty
  a_both: assert property (p_both) else $error("both-edge mode missed an edge");
  property p_edge;
    @(posedge mclk) disable iff (!nrst)
      enabled && !mode_change && capture_control_one.capture_mode_field == MODE_EDGE
      && (rise || fall) |-> capture;
  endproperty
  a_edge: assert property (p_edge) else $error("edge mode missed an edge");
  property p_div4;
    @(posedge mclk) disable iff (!nrst)
      capture_control_one.capture_mode_field == MODE_RISE4 && capture |-> presc == 4'h3;
  endproperty
  a_div4: assert property (p_div4) else $error("divide-by-4 capture off count");
  property p_div16;
    @(posedge mclk) disable iff (!nrst)
      capture_control_one.capture_mode_field == MODE_RISE16 && capture |-> presc == 4'hF;
  endproperty
  a_div16: assert property (p_div16) else $error("divide-by-16 capture off count");
  property p_presc_clear;
    @(posedge mclk) disable iff (!nrst) !enabled || mode_change |=> presc == 4'h0;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not restarted");
  property p_narrow;
    @(posedge mclk) disable iff (!nrst)
      push && !capture_control_one.wide_timer_select |=> mem[$past(wr_ptr)][31:16] == 16'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow capture has upper bits");
  property p_readback;
    @(posedge mclk) disable iff (!nrst)
      ##2 capture_timer_readback == $past(timer, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback lag wrong");
  property p_disabled;
    @(posedge mclk) disable iff (!nrst) !enabled |-> !capture;
  endproperty
  a_disabled: assert property (p_disabled) else $error("capture while deselected");

  c_capture: cover property (@(posedge mclk) disable iff (!nrst) push);
  c_div16: cover property (@(posedge mclk) disable iff (!nrst)
    capture && capture_control_one.capture_mode_field == MODE_RISE16);
  c_div4: cover property (@(posedge mclk) disable iff (!nrst)
    capture && capture_control_one.capture_mode_field == MODE_RISE4);
  c_overflow: cover property (@(posedge mclk) disable iff (!nrst) $rose(overflow));
  c_wide: cover property (@(posedge mclk) disable iff (!nrst)
    push && capture_control_one.wide_timer_select);
endmodule

//--- test/cap_source.sv
// Far-side model: external capture pin and internal trigger source
`timescale 1ns/1ps
module cap_source (
  // Requested levels
  input wire logic pin_lvl,
  input wire logic trg_lvl,
  // Event sources
  output logic capture_pin,
  output logic internal_trigger
);
  initial capture_pin = 1'b0;
  // The pin is asynchronous, so it moves off the clock grid
  always @(pin_lvl) capture_pin <= #3 pin_lvl;
  assign internal_trigger = trg_lvl;
endmodule

//--- test/input_capture_unit_tb.sv
// Self-checking bench for the input capture unit
`timescale 1ns/1ps
module input_capture_unit_tb;
  import capture_pkg::*;
  localparam int DEPTH = 4;
  logic mclk = 0, nrst = 0, trigger_select = 0, fifo_pop = 0, pop_en = 1;
  logic pin_lvl = 0, trg_lvl = 0, capture_pin, internal_trigger, fifo_valid, fifo_overflow;
  logic [31:0] fifo_data, capture_timer_readback, tm, h1, h2;
  capture_control_one_t capture_control_one = '0;
  logic s1, s2, prv, src, ovf, hit;
  logic [3:0] pm, psc, md;
  logic [31:0] q[$];
  int n_errors = 0, num_checks = 0, seed = 32'hacd3;

  initial forever #5 mclk = ~mclk;

  input_capture_unit #(.DEPTH(DEPTH), .PTR_W(2)) dut (.mclk(mclk), .nrst(nrst),
    .capture_control_one(capture_control_one), .trigger_select(trigger_select),
    .capture_pin(capture_pin), .internal_trigger(internal_trigger), .fifo_pop(fifo_pop),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_overflow(fifo_overflow),
    .capture_timer_readback(capture_timer_readback));
  cap_source partner (.pin_lvl(pin_lvl), .trg_lvl(trg_lvl), .capture_pin(capture_pin),
    .internal_trigger(internal_trigger));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Reference model; timer kept short of 16-bit wrap by the run length
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {s1, s2, prv, ovf, pm, psc, tm, h1, h2} <= '0;
    end else begin
      md = capture_control_one.capture_mode_field;
      src = trigger_select ? internal_trigger : s2;
      case (md)
        MODE_EDGE, MODE_BOTH: hit = src != prv;
        MODE_RISE: hit = src & ~prv;
        MODE_FALL: hit = ~src & prv;
        MODE_RISE4: hit = src & ~prv & (psc == PRESC_LAST4);
        MODE_RISE16: hit = src & ~prv & (psc == PRESC_LAST16);
        default: hit = 1'b0;
      endcase
      s1 <= capture_pin;
      s2 <= s1;
      prv <= src;
      pm <= md;
      h1 <= tm;
      h2 <= h1;
      if (!capture_control_one.capture_select || pm != md) psc <= '0;
      else if (src & ~prv & (md == MODE_RISE4 || md == MODE_RISE16)) psc <= hit ? '0 : psc + 4'h1;
      tm <= capture_control_one.capture_select ? tm + 32'h1 : '0;
      if (!capture_control_one.capture_select) ovf <= 1'b0;
      else if (hit && pm == md && !fifo_pop && q.size() >= DEPTH) ovf <= 1'b1;
      else if (hit && pm == md)
        q.push_back(capture_control_one.wide_timer_select ? tm : {16'h0, tm[15:0]});
    end
  end

  always @(negedge mclk) if (nrst) begin
    chk("fifo_valid", fifo_valid, q.size() != 0);
    chk("readback", capture_timer_readback, h2);
    chk("overflow", fifo_overflow, ovf);
    fifo_pop <= 1'b0;
    if (fifo_valid === 1'b1 && pop_en) begin
      chk("fifo_data", fifo_data, q.pop_front());
      fifo_pop <= 1'b1;
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk) nrst <= 1'b1;
    for (int m = 0; m < 8; m++) for (int k = 0; k < 4; k++) begin
      @(negedge mclk);
      // Codes above 5 are only ever written with capture deselected
      capture_control_one <= '{k[0], k != 2 && m < 6, m[3:0]};
      trigger_select <= k[1];
      repeat (160) begin
        @(negedge mclk);
        if (($random(seed) & 3) == 0) begin
          pin_lvl <= ~pin_lvl;
          trg_lvl <= ~trg_lvl;
        end
      end
    end
    // Fill the FIFO with the reader stalled, then drain and deselect
    pop_en <= 1'b0;
    capture_control_one <= '{1'b1, 1'b1, MODE_EDGE};
    trigger_select <= 1'b1;
    repeat (7) begin
      @(negedge mclk);
      trg_lvl <= ~trg_lvl;
    end
    repeat (3) @(negedge mclk);
    pop_en <= 1'b1;
    repeat (8) @(negedge mclk);
    capture_control_one.capture_select <= 1'b0;
    repeat (4) @(negedge mclk);
    print_verdict();
  end

  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule
